// ===== rtl/comp2_consts.svh
// Offsets, field positions, masks and codes for the comparator 2 block.
// Assumes a plain register port with byte offsets and 32-bit data.
// Notes on behaviour
// - Bit 19 mirrors comparator output, read-only
// - Mirror reads 1 when plus above minus
// - Blanking source: none, timer A, timer B
// - Bits 15:14 drive hysteresis level
// - Bit 13 inverts comparator output
// - Bits 12:9 route output to timer input
// - Plus select 0xxx floating, 1xxx sources
// - Plus code 1000 picks shared/DAC/alternate
// - Bits 3:1 select minus input source
// - Bit 0 switches comparator on
// - Filter window is field plus one
// - Toggle when opposite samples reach threshold
// - All four registers reset to zero
// - Sample tick every prescale plus one
// - Interrupt flag bit 1, write zero clears
`ifndef COMP2_CONSTS_SVH
`define COMP2_CONSTS_SVH
`define OFS_CTRL    8'h20
`define OFS_FILC    8'h24
`define OFS_FILP    8'h28
`define OFS_ISTS    8'h38
`define RST_WORD    32'h0000_0000
`define CTRL_WMASK  32'h0007_FFEF
`define FILC_WMASK  32'h0000_07FF
`define FILP_WMASK  32'h0000_FFFF
`define B_OUT       19
`define B_BLK_HI    18
`define B_BLK_LO    16
`define B_HYS_HI    15
`define B_HYS_LO    14
`define B_POL       13
`define B_RT_HI     12
`define B_RT_LO     9
`define B_INP_HI    8
`define B_INP_LO    5
`define B_INM_HI    3
`define B_INM_LO    1
`define B_EN        0
`define B_WIN_HI    10
`define B_WIN_LO    6
`define B_THR_HI    5
`define B_THR_LO    1
`define B_FEN       0
`define B_PSC_HI    15
`define B_PSC_LO    0
`define B_IRQ       1
`define BLK_TA      3'h1
`define BLK_TB      3'h2
`define RT_NONE     4'h0
`define RT_BREAK_A  4'h1
`define RT_BREAK_B  4'hD
`define RT_BOTH     4'hE
`define RT_ETR      4'hF
`define INP_SHARED  4'h8
`define NP_DAC      2'h0
`define NP_SHARED   2'h1
`define NP_ALT      2'h2
`define WIN_BITS    32
`endif

// ===== rtl/comp2_pkg.sv
// State types for the comparator 2 conditioning block.
// Assumes the constants header is included where fields are decoded.
package comp2_pkg;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] filc;
        logic [15:0] filp;
        logic        irq;
        logic        sync1;
        logic        sync2;
        logic        cond;
        logic [15:0] tin;
        logic [31:0] rdata;
        logic [1:0]  npath;
    } top_state_t;
    typedef struct packed {
        logic [31:0] hist;
        logic        out;
    } filt_state_t;
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } psc_state_t;
endpackage : comp2_pkg

// ===== rtl/comp2_filt_if.sv
// Signals shared by the control block, the prescaler and the vote filter.
// Assumes all three run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface comp2_filt_if;
    logic        tick;
    logic        sample;
    logic        en;
    logic [4:0]  win;
    logic [4:0]  thr;
    logic [15:0] psc;
    logic        filtered;
    modport ctrl (output sample, en, win, thr, psc, input tick, filtered);
    modport pre  (input psc, output tick);
    modport filt (input tick, sample, en, win, thr, output filtered);
endinterface : comp2_filt_if
`default_nettype wire

// ===== rtl/comp2_prescaler.sv
// Sample tick generator for the output filter.
// Assumes the prescale value is stable or changes rarely.
`timescale 1ns/100ps
`default_nettype none
`include "comp2_consts.svh"
module comp2_prescaler
    import comp2_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    comp2_filt_if.pre       fif
);
    psc_state_t state_r;
    psc_state_t state_nxt;

    // Wrap at prescale; >= guards a value lowered mid-count
    always_comb begin
        state_nxt = state_r;
        if (state_r.cnt >= fif.psc) begin
            state_nxt.cnt  = 16'h0000;
            state_nxt.tick = 1'b1;
        end else begin
            state_nxt.cnt  = state_r.cnt + 16'h0001;
            state_nxt.tick = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) state_r <= '0;
        else          state_r <= state_nxt;
    end

    assign fif.tick = state_r.tick;

    property p_tick_rate;
        @(posedge i_clk) disable iff (!i_rst_n)
        (fif.psc == 16'h0000) && $stable(fif.psc) |=> fif.tick;
    endproperty
    a_tick_rate: assert property (p_tick_rate)
        else $error("tick missing at prescale zero");
endmodule : comp2_prescaler
`default_nettype wire

// ===== rtl/comp2_vote_filter.sv
// Majority style vote filter over a sliding sample window.
// Assumes threshold is programmed above half the window.
`timescale 1ns/100ps
`default_nettype none
`include "comp2_consts.svh"
module comp2_vote_filter
    import comp2_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    comp2_filt_if.filt      fif
);
    filt_state_t           state_r;
    filt_state_t           state_nxt;
    logic [31:0]           shifted;
    logic [`WIN_BITS-1:0]  in_win;
    logic [5:0]            ones;
    logic [5:0]            opp;

    assign shifted = {state_r.hist[30:0], fif.sample};

    // Keep only samples inside the programmed window
    genvar gi;
    generate
        for (gi = 0; gi < `WIN_BITS; gi++) begin : g_win
            assign in_win[gi] = shifted[gi] & (gi <= int'(fif.win));
        end
    endgenerate

    // Count opposite-state samples in the new window
    always_comb begin
        ones = 6'h00;
        for (int k = 0; k < `WIN_BITS; k++) ones = ones + {5'h00, in_win[k]};
        opp = state_r.out ? ({1'b0, fif.win} + 6'h01 - ones) : ones;
    end

    // Toggle only on a tick with enough votes; bypass when off
    always_comb begin
        state_nxt = state_r;
        if (fif.tick) state_nxt.hist = shifted;
        if (!fif.en) begin
            state_nxt.out = fif.sample;
        end else if (fif.tick && (opp >= {1'b0, fif.thr})) begin
            state_nxt.out = ~state_r.out;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) state_r <= '0;
        else          state_r <= state_nxt;
    end

    assign fif.filtered = state_r.out;

    sequence s_vote_ok;
        fif.en && fif.tick && (opp >= {1'b0, fif.thr});
    endsequence
    sequence s_vote_low;
        fif.en && (!fif.tick || (opp < {1'b0, fif.thr}));
    endsequence

    property p_switch;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_vote_ok |=> (fif.filtered != $past(fif.filtered));
    endproperty
    a_switch: assert property (p_switch)
        else $error("filter did not switch on enough votes");

    property p_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_vote_low |=> $stable(fif.filtered);
    endproperty
    a_hold: assert property (p_hold)
        else $error("filter switched without enough votes");
endmodule : comp2_vote_filter
`default_nettype wire

// ===== rtl/comp2_conditioning.sv
// Register file and output conditioning for comparator 2.
// Assumes a raw comparator level asynchronous to i_clk and
// timer blanking levels synchronous to i_clk.
`timescale 1ns/100ps
`default_nettype none
`include "comp2_consts.svh"
module comp2_conditioning
    import comp2_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_cmp_raw,
    input  wire logic        i_window_mode,
    input  wire logic        i_comparator1_dac_input_flag,
    input  wire logic        i_blank_timer_a_oc5,
    input  wire logic        i_blank_timer_b_oc5,
    output logic             o_enable,
    output logic      [1:0]  o_hysteresis_level,
    output logic      [3:0]  o_noninverting_source_select,
    output logic      [1:0]  o_noninverting_path,
    output logic      [2:0]  o_inverting_source_select,
    output logic      [15:0] o_timer_in,
    output logic             o_comparator2_irq_flag
);
    top_state_t   state_r;
    top_state_t   state_nxt;
    comp2_filt_if fif ();

    ////////////////////////////////////////////////////////////////
    // Field views of the stored registers

    logic       en;
    logic       output_invert;
    logic [2:0] blk;
    logic [3:0] route;
    logic [3:0] inp;
    logic       blank;
    logic       cond;
    logic       rise;
    logic [15:0] route_hit;
    logic [1:0] npath;

    assign en    = state_r.ctrl[`B_EN];
    assign output_invert   = state_r.ctrl[`B_POL];
    assign blk   = state_r.ctrl[`B_BLK_HI:`B_BLK_LO];
    assign route = state_r.ctrl[`B_RT_HI:`B_RT_LO];
    assign inp   = state_r.ctrl[`B_INP_HI:`B_INP_LO];

    ////////////////////////////////////////////////////////////////
    // Filter and prescaler hookup

    // Polarity applied before the filter so votes see the final sense
    assign fif.sample = state_r.sync2 ^ output_invert;
    assign fif.en     = state_r.filc[`B_FEN];
    assign fif.win    = state_r.filc[`B_WIN_HI:`B_WIN_LO];
    assign fif.thr    = state_r.filc[`B_THR_HI:`B_THR_LO];
    assign fif.psc    = state_r.filp[`B_PSC_HI:`B_PSC_LO];

    comp2_prescaler u_prescaler (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .fif     (fif.pre)
    );

    comp2_vote_filter u_filter (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .fif     (fif.filt)
    );

    ////////////////////////////////////////////////////////////////
    // Blanking and enable gating

    // Reserved blanking codes act as no blanking
    always_comb begin
        unique case (blk)
            `BLK_TA: blank = i_blank_timer_a_oc5;
            `BLK_TB: blank = i_blank_timer_b_oc5;
            default: blank = 1'b0;
        endcase
    end

    // Blanking wins over the filtered level
    assign cond = en & fif.filtered & ~blank;
    assign rise = cond & ~state_r.cond;

    ////////////////////////////////////////////////////////////////
    // Timer input routing, one output bit per route code

    // Code 0 is reserved, code 14 feeds both break inputs
    genvar gk;
    generate
        for (gk = 0; gk < 16; gk++) begin : g_route
            localparam logic [3:0] CODE = 4'(gk);
            if (CODE == `RT_NONE || CODE == `RT_BOTH) begin : g_off
                assign route_hit[gk] = 1'b0;
            end else if (CODE == `RT_BREAK_A || CODE == `RT_BREAK_B) begin : g_brk
                assign route_hit[gk] = (route == CODE) || (route == `RT_BOTH);
            end else begin : g_one
                assign route_hit[gk] = (route == CODE);
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Non-inverting source path for the shared select code

    // Alternate pin only in window mode with the DAC flag of comparator 1
    always_comb begin
        if (inp != `INP_SHARED) begin
            npath = `NP_DAC;
        end else if (i_window_mode && i_comparator1_dac_input_flag) begin
            npath = `NP_ALT;
        end else if (i_window_mode) begin
            npath = `NP_SHARED;
        end else begin
            npath = `NP_DAC;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Next state: registers, synchroniser, outputs

    always_comb begin
        state_nxt       = state_r;
        // Two-stage synchroniser on the raw analog level
        state_nxt.sync1 = i_cmp_raw;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.cond  = cond;
        state_nxt.npath = npath;
        // Forward to the routed timer input only while conditioned high
        state_nxt.tin   = cond ? route_hit : 16'h0000;
        // Writes keep reserved and read-only bits at zero
        if (i_wr) begin
            unique case (i_addr)
                `OFS_CTRL: state_nxt.ctrl = i_wdata & `CTRL_WMASK;
                `OFS_FILC: state_nxt.filc = i_wdata & `FILC_WMASK;
                `OFS_FILP: state_nxt.filp = i_wdata[`B_PSC_HI:`B_PSC_LO];
                `OFS_ISTS: if (!i_wdata[`B_IRQ]) state_nxt.irq = 1'b0;
                default: ;
            endcase
        end
        // A new edge beats a clear in the same cycle
        if (rise) state_nxt.irq = 1'b1;
        // Read data stands only in the cycle after the strobe
        state_nxt.rdata = `RST_WORD;
        if (i_rd) begin
            unique case (i_addr)
                `OFS_CTRL: begin
                    state_nxt.rdata         = state_r.ctrl;
                    state_nxt.rdata[`B_OUT] = state_r.sync2;
                end
                `OFS_FILC: state_nxt.rdata = state_r.filc;
                `OFS_FILP: state_nxt.rdata = {16'h0000, state_r.filp};
                `OFS_ISTS: state_nxt.rdata[`B_IRQ] = state_r.irq;
                default:   state_nxt.rdata = `RST_WORD;
            endcase
        end
    end

    // Everything resets to zero: off, unfiltered, unblanked, unrouted
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs straight from flops

    assign o_rdata                      = state_r.rdata;
    assign o_enable                     = state_r.ctrl[`B_EN];
    assign o_hysteresis_level           = state_r.ctrl[`B_HYS_HI:`B_HYS_LO];
    assign o_noninverting_source_select = state_r.ctrl[`B_INP_HI:`B_INP_LO];
    assign o_noninverting_path          = state_r.npath;
    assign o_inverting_source_select    = state_r.ctrl[`B_INM_HI:`B_INM_LO];
    assign o_timer_in                   = state_r.tin;
    assign o_comparator2_irq_flag       = state_r.irq;

    ////////////////////////////////////////////////////////////////
    // Checks

    property p_mirror_read;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rd && (i_addr == `OFS_CTRL) |=> o_rdata[`B_OUT] == $past(state_r.sync2);
    endproperty
    a_mirror_read: assert property (p_mirror_read)
        else $error("status bit does not mirror output");

    property p_mirror_lag;
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> ##1 state_r.sync2 == $past(i_cmp_raw, 2);
    endproperty
    a_mirror_lag: assert property (p_mirror_lag)
        else $error("synchronised level wrong");

    property p_blank;
        @(posedge i_clk) disable iff (!i_rst_n)
        (blk == `BLK_TA) && i_blank_timer_a_oc5 |=> o_timer_in == 16'h0000;
    endproperty
    a_blank: assert property (p_blank)
        else $error("output forwarded during blanking");

    property p_hysteresis_level;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_wr && (i_addr == `OFS_CTRL)
            |=> o_hysteresis_level == $past(i_wdata[`B_HYS_HI:`B_HYS_LO]);
    endproperty
    a_hysteresis_level: assert property (p_hysteresis_level)
        else $error("hysteresis field not applied");

    property p_both;
        @(posedge i_clk) disable iff (!i_rst_n)
        (route == `RT_BOTH) && $stable(route) && cond
            |=> o_timer_in[`RT_BREAK_A] && o_timer_in[`RT_BREAK_B] && !o_timer_in[`RT_BOTH];
    endproperty
    a_both: assert property (p_both)
        else $error("dual break routing wrong");

    property p_etr;
        @(posedge i_clk) disable iff (!i_rst_n)
        (route == `RT_ETR) && cond |=> o_timer_in == 16'h8000;
    endproperty
    a_etr: assert property (p_etr)
        else $error("trigger routing wrong");

    property p_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        !en |=> o_timer_in == 16'h0000;
    endproperty
    a_off: assert property (p_off)
        else $error("output active while disabled");

    property p_alt;
        @(posedge i_clk) disable iff (!i_rst_n)
        (inp == `INP_SHARED) && i_window_mode && i_comparator1_dac_input_flag
            |=> o_noninverting_path == `NP_ALT;
    endproperty
    a_alt: assert property (p_alt)
        else $error("alternate pin not chosen");

    property p_irq;
        @(posedge i_clk) disable iff (!i_rst_n)
        rise |=> o_comparator2_irq_flag ##1 (o_comparator2_irq_flag
            || $past(i_wr && i_addr == `OFS_ISTS));
    endproperty
    a_irq: assert property (p_irq)
        else $error("event flag lost");

    // Second break input alone, the other break bit stays quiet
    property p_route_b;
        @(posedge i_clk) disable iff (!i_rst_n)
        (route == `RT_BREAK_B) && cond |=> o_timer_in == 16'h2000;
    endproperty
    a_route_b: assert property (p_route_b)
        else $error("second break routing wrong");

    // Reserved route code must never reach a timer
    property p_route_none;
        @(posedge i_clk) disable iff (!i_rst_n)
        (route == `RT_NONE) |=> o_timer_in == 16'h0000;
    endproperty
    a_route_none: assert property (p_route_none)
        else $error("reserved route code forwarded");

    property p_blank_b;
        @(posedge i_clk) disable iff (!i_rst_n)
        (blk == `BLK_TB) && i_blank_timer_b_oc5 |=> o_timer_in == 16'h0000;
    endproperty
    a_blank_b: assert property (p_blank_b)
        else $error("output forwarded during second blanking");

    property p_enable;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_wr && (i_addr == `OFS_CTRL) |=> o_enable == $past(i_wdata[`B_EN]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable bit not applied");

    property p_inv_sel;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_wr && (i_addr == `OFS_CTRL)
            |=> o_inverting_source_select == $past(i_wdata[`B_INM_HI:`B_INM_LO]);
    endproperty
    a_inv_sel: assert property (p_inv_sel)
        else $error("minus select not applied");

    property p_np_sel;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_wr && (i_addr == `OFS_CTRL)
            |=> o_noninverting_source_select == $past(i_wdata[`B_INP_HI:`B_INP_LO]);
    endproperty
    a_np_sel: assert property (p_np_sel)
        else $error("plus select not applied");

    // Status and reserved bits must never hold written ones
    property p_ctrl_mask;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_wr && (i_addr == `OFS_CTRL) |=> (state_r.ctrl & ~`CTRL_WMASK) == `RST_WORD;
    endproperty
    a_ctrl_mask: assert property (p_ctrl_mask)
        else $error("read-only or reserved bit stored");

    property p_np_shared;
        @(posedge i_clk) disable iff (!i_rst_n)
        (inp == `INP_SHARED) && i_window_mode && !i_comparator1_dac_input_flag
            |=> o_noninverting_path == `NP_SHARED;
    endproperty
    a_np_shared: assert property (p_np_shared)
        else $error("shared pin not chosen");

    // Clear with zero and no competing edge leaves the flag low
    sequence s_flag_clear;
        i_wr && (i_addr == `OFS_ISTS) && !i_wdata[`B_IRQ] && !rise;
    endsequence
    property p_irq_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_flag_clear |=> !o_comparator2_irq_flag;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("event flag not cleared");
endmodule : comp2_conditioning
`default_nettype wire

// ===== verification/comp2_far_side.sv
// Far-side model: analog comparator core and timer blanking outputs.
// Assumes blanking levels are launched on the rising edge of i_clk.
`timescale 1ns/100ps
`default_nettype none
module comp2_far_side (
    input  wire logic i_clk,
    input  wire logic i_enable,
    input  wire logic i_plus_above,
    input  wire logic i_blank_a_req,
    input  wire logic i_blank_b_req,
    output logic      o_cmp_raw,
    output logic      o_blank_a,
    output logic      o_blank_b
);
    ////////////////////////////////////////////////////////////////
    // Powered-down core holds its output low, so nothing leaks when off
    assign o_cmp_raw = i_enable & i_plus_above;

    // Timer compare outputs switch just after the clock edge
    always @(posedge i_clk) begin
        o_blank_a <= i_blank_a_req;
        o_blank_b <= i_blank_b_req;
    end
endmodule : comp2_far_side
`default_nettype wire

// ===== verification/comp2_conditioning_tb.sv
// Self-checking bench for the comparator 2 conditioning block.
// Assumes the far-side model stands in for the analog core and timers.
`timescale 1ns/100ps
`default_nettype none
`include "comp2_consts.svh"
module comp2_conditioning_tb;
    logic        i_clk   = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        lvl     = 1'b0;
    logic        wm      = 1'b0;
    logic        dflag   = 1'b0;
    logic        ba_req  = 1'b0;
    logic        bb_req  = 1'b0;
    logic [31:0] rdata;
    logic        raw, blank_a, blank_b, en, irq;
    logic [1:0]  hysteresis_level, npath;
    logic [3:0]  psel;
    logic [2:0]  msel;
    logic [15:0] tin;
    logic [31:0] ctrl_m, rv;
    int          err_total = 0;
    int          checks    = 0;
    int          n;

    always #10 i_clk = ~i_clk;

    comp2_conditioning dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cmp_raw(raw),
        .i_window_mode(wm), .i_comparator1_dac_input_flag(dflag),
        .i_blank_timer_a_oc5(blank_a), .i_blank_timer_b_oc5(blank_b),
        .o_enable(en), .o_hysteresis_level(hysteresis_level),
        .o_noninverting_source_select(psel), .o_noninverting_path(npath),
        .o_inverting_source_select(msel), .o_timer_in(tin),
        .o_comparator2_irq_flag(irq)
    );

    comp2_far_side far (
        .i_clk(i_clk), .i_enable(en), .i_plus_above(lvl),
        .i_blank_a_req(ba_req), .i_blank_b_req(bb_req),
        .o_cmp_raw(raw), .o_blank_a(blank_a), .o_blank_b(blank_b)
    );

    ////////////////////////////////////////////////////////////////
    // Compare and count; four-state equality so X never matches
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // One-cycle write strobe beside address and data
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic set_in(input logic l, input logic a, input logic b);
        @(posedge i_clk);
        lvl    <= l;
        ba_req <= a;
        bb_req <= b;
    endtask : set_in

    // Four edges of path latency plus margin, then sample off the edge
    task automatic wait_n(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask : wait_n

    // Reference model of the conditioned, routed output
    function automatic logic [15:0] exp_tin(input logic [31:0] c, input logic l,
                                            input logic a, input logic b);
        logic [15:0] t;
        logic        act;
        t   = 16'h0000;
        act = c[0] & ((c[0] & l) ^ c[13])
              & ~(((c[18:16] == `BLK_TA) & a) | ((c[18:16] == `BLK_TB) & b));
        if (act && c[12:9] == `RT_BOTH) t = 16'h2002;
        else if (act && c[12:9] != `RT_NONE) t[c[12:9]] = 1'b1;
        return t;
    endfunction : exp_tin

    ////////////////////////////////////////////////////////////////
    initial begin
        rv = $urandom(45);
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        // Everything starts cleared
        rd_reg(`OFS_CTRL, rv);
        chk(rv, `RST_WORD);
        rd_reg(`OFS_FILC, rv);
        chk(rv, `RST_WORD);
        chk({tin, irq, en}, 32'h0);
        // Random settings; reserved bits kept clear, the status bit is not
        repeat (4) begin
            ctrl_m = $urandom() & 32'h000F_FFEE;
            wr_reg(`OFS_CTRL, ctrl_m);
            rd_reg(`OFS_CTRL, rv);
            chk(rv, ctrl_m & `CTRL_WMASK);
            chk({hysteresis_level, psel, msel}, {ctrl_m[15:14], ctrl_m[8:5], ctrl_m[3:1]});
            wr_reg(`OFS_CTRL, ctrl_m | 32'h1);
            wait_n(1);
            chk(en, 1'b1);
            ctrl_m = $urandom() & 32'h0000_07FE;
            wr_reg(`OFS_FILC, ctrl_m);
            rd_reg(`OFS_FILC, rv);
            chk(rv, ctrl_m);
        end
        rd_reg(8'h2C, rv);
        chk(rv, 32'h0);
        wr_reg(`OFS_FILC, 32'h0);
        wr_reg(`OFS_FILP, 32'h0);
        // Every route code, both polarities, both levels
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 16; r++) begin
                for (int l = 0; l < 2; l++) begin
                    ctrl_m = 32'h1 | (p << 13) | (r << 9);
                    wr_reg(`OFS_CTRL, ctrl_m);
                    set_in(l[0], 1'b0, 1'b0);
                    wait_n(6);
                    chk(tin, exp_tin(ctrl_m, l[0], 1'b0, 1'b0));
                    rd_reg(`OFS_CTRL, rv);
                    chk(rv, ctrl_m | (l << 19));
                end
            end
        end
        // Blanking codes 0 to 3 against each timer level
        for (int k = 0; k < 16; k++) begin
            ctrl_m = 32'h0000_0201 | (k[3:2] << 16);
            wr_reg(`OFS_CTRL, ctrl_m);
            set_in(1'b1, k[0], k[1]);
            wait_n(6);
            chk(tin, exp_tin(ctrl_m, 1'b1, k[0], k[1]));
        end
        // Shared plus-input code picks its path from window mode
        wr_reg(`OFS_CTRL, 32'h0000_0100);
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            wm    <= k[0];
            dflag <= k[1];
            wait_n(4);
            chk(npath, !k[0] ? `NP_DAC : (k[1] ? `NP_ALT : `NP_SHARED));
        end
        // Sticky flag: set by a rising output, cleared only by zero
        wr_reg(`OFS_CTRL, 32'h0000_0201);
        set_in(1'b0, 1'b0, 1'b0);
        wait_n(6);
        wr_reg(`OFS_ISTS, 32'h0);
        rd_reg(`OFS_ISTS, rv);
        chk(rv, 32'h0);
        set_in(1'b1, 1'b0, 1'b0);
        wait_n(6);
        wr_reg(`OFS_ISTS, 32'h2);
        rd_reg(`OFS_ISTS, rv);
        chk(rv, 32'h2);
        chk(irq, 1'b1);
        wr_reg(`OFS_ISTS, 32'h0);
        rd_reg(`OFS_ISTS, rv);
        chk(rv, 32'h0);
        // Filter: 5 samples, threshold 3, tick every 16 cycles
        set_in(1'b0, 1'b0, 1'b0);
        wr_reg(`OFS_FILP, 32'h0000_000F);
        wr_reg(`OFS_FILC, 32'h0000_0107);
        wait_n(120);
        // A 32-cycle pulse gives only two samples, too few to flip
        n = 0;
        @(posedge i_clk);
        lvl <= 1'b1;
        for (int c = 0; c < 150; c++) begin
            @(posedge i_clk);
            if (c == 31) lvl <= 1'b0;
            #1;
            if (tin !== 16'h0) n++;
        end
        chk(n, 0);
        // A held level needs three ticks before the output follows
        @(posedge i_clk);
        lvl <= 1'b1;
        n = 0;
        while (tin[1] !== 1'b1 && n <= 200) begin
            @(posedge i_clk);
            #1 n++;
        end
        if (n > 200) err_total++;
        chk(n >= 33 && n <= 60, 1'b1);
        close_out();
    end
endmodule : comp2_conditioning_tb
`default_nettype wire
